// File: rtl/smb_defs.vh
// Constants shared by the stream master burst control files.
`ifndef SMB_DEFS_VH
`define SMB_DEFS_VH

// Time base.
`define SMB_CLK_NS 25
`define SMB_FAST_DIV 2
`define SMB_ADL_NS 50
`define SMB_ADL_CYC ((`SMB_ADL_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_CMD_MIN_NS 100
`define SMB_CMD_MIN_CYC ((`SMB_CMD_MIN_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_FAST_NS 50
`define SMB_RELEASE_NS 7800
`define SMB_RELEASE_TICKS (`SMB_RELEASE_NS / `SMB_FAST_NS)

// Register offsets.
`define SMB_REG_CTRL 4'h0
`define SMB_REG_STATUS 4'h4
`define SMB_REG_COUNT 4'h8

// Control register fields and reset value.
`define SMB_CTRL_EN 0
`define SMB_CTRL_STREAM 1
`define SMB_CTRL_RST 2'h0

// Status register fields.
`define SMB_ST_STATE_LSB 0
`define SMB_ST_OWNER 8
`define SMB_ST_PRE 9
`define SMB_ST_LATE 10
`define SMB_ST_LVL_LSB 12

// Slave stream request codes, {req1_n, req0_n}.
`define SMB_SDR_STREAM 2'h2
`define SMB_SDR_NORMAL 2'h3

// Command codes, {mem_io_select, status1_n, status0_n}.
`define SMB_CMD_IO_RD 3'h1
`define SMB_CMD_IO_WR 3'h2
`define SMB_CMD_MEM_RD 3'h5
`define SMB_CMD_MEM_WR 3'h6

// Transfer length codes.
`define SMB_LEN_4 2'h0
`define SMB_LEN_1 2'h1
`define SMB_LEN_2 2'h2
`define SMB_LEN_3 2'h3
`define SMB_STREAM_INCR 3'h4

`endif

// File: rtl/smb_tick.v
// Enable pulse divider that derives the fast bus rate from the system clock.
`timescale 1ns/100ps
`default_nettype none
module smb_tick #(
  parameter DIV = 2
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Enable pulse
  output reg tick_o
);
  reg [7:0] cnt_q;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/smb_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module smb_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Fill level
  output reg [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  wire push;
  wire pop;

  assign in_ready_o = (level_o != DEPTH[AW:0]);
  assign out_valid_o = (level_o != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      level_o <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        level_o <= level_o + 1'b1;
      end else if (pop && !push) begin
        level_o <= level_o - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/smb_burst_ctrl.v
// Bus master burst, strobe and status sequencer with outgoing data buffer.
//
// Overview of operation
// - Withdrawn burst request drops bus burst indication.
// - Running stream ends by normal master termination.
// - Ownership released only after current command completes.
// - Status lines released when the burst ends; a normal command releases them at the minimum command length.
// - Slave codes: 11 normal, 10 streaming, others reserved.
// - Select and status encode IO/memory read/write.
// - Length code: 00=4, 01=1, 10=2, 11=3 bytes.
// - Status derived from local write/read and memory/IO.
//
// Our own choices: the register addresses and the plain strobed port.
`include "smb_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module smb_burst_ctrl #(
  parameter DW = 32,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Local data source
  input wire src_valid_i,
  output wire src_ready_o,
  input wire [DW-1:0] src_data_i,
  // Local master pins
  input wire bus_granted_n_i,
  input wire local_burst_req_n_i,
  input wire stream_enable_n_i,
  input wire local_write_read_i,
  input wire local_mem_io_i,
  input wire xfer_len_bit0_i,
  input wire xfer_len_bit1_i,
  // Bus side inputs
  input wire bus_req_n_a_i,
  input wire channel_ready_return_i,
  input wire slave_stream_req0_n_i,
  input wire slave_stream_req1_n_i,
  // Ownership and burst indication
  output reg master_owns_bus_n_o,
  output reg burst_ind_n_o,
  // Status lines, driven while their enable is low
  output reg bus_status0_n_o,
  output reg bus_status1_n_o,
  output reg mem_io_select_o,
  output reg status_oe_n_o,
  // Command strobes
  output reg addr_decode_latch_n_o,
  output reg cmd_n_o,
  output reg stream_strobe_n_o,
  // Transfer results
  output reg xfer_o,
  output reg [DW-1:0] xfer_data_o,
  output reg [3:0] byte_en_n_o,
  output reg [2:0] addr_incr_o
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADLE = 6'h02;
  localparam [5:0] S_ADL = 6'h04;
  localparam [5:0] S_CMD = 6'h08;
  localparam [5:0] S_STRM = 6'h10;
  localparam [5:0] S_NEXT = 6'h20;
  localparam NSYNC = 10;
  localparam integer ADL_LAST = `SMB_ADL_CYC - 1;
  localparam integer CMD_LAST = `SMB_CMD_MIN_CYC - 1;

  // Status code from the local direction and space inputs.
  function [2:0] cmd_code;
    input mio;
    input wr;
    begin
      if (mio && wr) begin
        cmd_code = `SMB_CMD_MEM_WR;
      end else if (mio) begin
        cmd_code = `SMB_CMD_MEM_RD;
      end else if (wr) begin
        cmd_code = `SMB_CMD_IO_WR;
      end else begin
        cmd_code = `SMB_CMD_IO_RD;
      end
    end
  endfunction

  // Active low byte enables and address step for a length code.
  function [6:0] len_decode;
    input [1:0] len;
    begin
      case (len)
        `SMB_LEN_1: len_decode = {4'he, 3'h1};
        `SMB_LEN_2: len_decode = {4'hc, 3'h2};
        `SMB_LEN_3: len_decode = {4'h8, 3'h3};
        default: len_decode = {4'h0, 3'h4};
      endcase
    end
  endfunction

  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [2:0] cnt_q;
  reg [1:0] ctrl_q;
  reg pre_seen_q;
  reg late_q;
  reg [7:0] pre_tick_q;
  reg [15:0] count_q;
  wire tick;
  wire grant_n_s;
  wire burst_req_n_s;
  wire stream_enable_n_n_s;
  wire lwr_s;
  wire lmio_s;
  wire [1:0] len_s;
  wire pre_n_s;
  wire channel_ready_s;
  wire [1:0] sdr_s;
  wire fifo_valid;
  wire [DW-1:0] fifo_data;
  wire [FIFO_AW:0] fifo_level;
  wire burst_live;
  wire foreign_pre;
  wire stream_ok;
  wire slot;
  wire fall_slot;
  wire norm_done;
  wire pop;
  wire [6:0] len_dec;

  // Every pin input passes two flip-flops first.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= {NSYNC{1'b1}};
      sync2_q <= {NSYNC{1'b1}};
    end else begin
      sync1_q <= {bus_granted_n_i, local_burst_req_n_i, stream_enable_n_i,
                  local_write_read_i, local_mem_io_i, xfer_len_bit1_i,
                  xfer_len_bit0_i, bus_req_n_a_i, channel_ready_return_i, slave_stream_req1_n_i};
      sync2_q <= sync1_q;
    end
  end

  reg slave_stream_req0_n_1_q;
  reg slave_stream_req0_n_2_q;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slave_stream_req0_n_1_q <= 1'b1;
      slave_stream_req0_n_2_q <= 1'b1;
    end else begin
      slave_stream_req0_n_1_q <= slave_stream_req0_n_i;
      slave_stream_req0_n_2_q <= slave_stream_req0_n_1_q;
    end
  end

  assign grant_n_s = sync2_q[9];
  assign burst_req_n_s = sync2_q[8];
  assign stream_enable_n_n_s = sync2_q[7];
  assign lwr_s = sync2_q[6];
  assign lmio_s = sync2_q[5];
  assign len_s = sync2_q[4:3];
  assign pre_n_s = sync2_q[2];
  assign channel_ready_s = sync2_q[1];
  assign sdr_s = {sync2_q[0], slave_stream_req0_n_2_q};

  smb_tick #(
    .DIV(`SMB_FAST_DIV)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  smb_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i(src_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data),
    .level_o(fifo_level)
  );

  assign burst_live = ~burst_req_n_s & ctrl_q[`SMB_CTRL_EN];
  assign foreign_pre = ~master_owns_bus_n_o & ~pre_n_s;
  assign stream_ok = ~stream_enable_n_n_s & ctrl_q[`SMB_CTRL_STREAM]
                     & (sdr_s == `SMB_SDR_STREAM);
  assign slot = tick;
  assign fall_slot = slot & ~cmd_n_o & stream_strobe_n_o;
  assign norm_done = (cnt_q == 3'h0) & channel_ready_s & fifo_valid;
  assign len_dec = len_decode(len_s);
  // A word leaves the buffer at the end of a normal command, or at a
  // streaming strobe fall, or at the final command rise, while the slave is ready.
  assign pop = ((state_q == S_CMD) & norm_done) |
               ((state_q == S_STRM) & fall_slot & channel_ready_s & fifo_valid);

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (!grant_n_s && burst_live) begin
          state_d = S_ADLE;
        end
      end
      S_ADLE: begin
        if (tick) begin
          state_d = S_ADL;
        end
      end
      S_ADL: begin
        if (cnt_q == 3'h0) begin
          state_d = stream_ok ? S_STRM : S_CMD;
        end
      end
      S_CMD: begin
        if (norm_done) begin
          state_d = S_NEXT;
        end
      end
      S_STRM: begin
        if (fall_slot && sdr_s != `SMB_SDR_STREAM) begin
          state_d = S_NEXT;
        end
      end
      S_NEXT: begin
        state_d = burst_live ? S_ADLE : S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      master_owns_bus_n_o <= 1'b1;
      burst_ind_n_o <= 1'b1;
      bus_status0_n_o <= 1'b1;
      bus_status1_n_o <= 1'b1;
      mem_io_select_o <= 1'b0;
      status_oe_n_o <= 1'b1;
      addr_decode_latch_n_o <= 1'b1;
      cmd_n_o <= 1'b1;
      stream_strobe_n_o <= 1'b1;
      xfer_o <= 1'b0;
      xfer_data_o <= {DW{1'b0}};
      byte_en_n_o <= 4'hf;
      addr_incr_o <= 3'h0;
    end else begin
      state_q <= state_d;
      xfer_o <= pop;
      burst_ind_n_o <= ~(~master_owns_bus_n_o & burst_live);
      if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (pop) begin
        xfer_data_o <= fifo_data;
        if (state_q == S_STRM) begin
          byte_en_n_o <= 4'h0;
          addr_incr_o <= `SMB_STREAM_INCR;
        end else begin
          byte_en_n_o <= len_dec[6:3];
          addr_incr_o <= len_dec[2:0];
        end
      end
      case (state_q)
        S_IDLE: begin
          if (state_d == S_ADLE) begin
            master_owns_bus_n_o <= 1'b0;
          end
        end
        S_ADLE: begin
          {mem_io_select_o, bus_status1_n_o, bus_status0_n_o}
            <= cmd_code(lmio_s, lwr_s);
          status_oe_n_o <= 1'b0;
          if (tick) begin
            addr_decode_latch_n_o <= 1'b0;
            cnt_q <= ADL_LAST[2:0];
          end
        end
        S_ADL: begin
          if (cnt_q == 3'h0) begin
            addr_decode_latch_n_o <= 1'b1;
            cmd_n_o <= 1'b0;
            stream_strobe_n_o <= 1'b0;
            cnt_q <= CMD_LAST[2:0];
          end
        end
        S_CMD: begin
          // Status always goes away at the minimum command length.
          if (cnt_q == 3'h0) begin
            status_oe_n_o <= 1'b1;
          end
          if (norm_done) begin
            cmd_n_o <= 1'b1;
            stream_strobe_n_o <= 1'b1;
          end
        end
        S_STRM: begin
          if (stream_enable_n_n_s || !burst_live || sdr_s != `SMB_SDR_STREAM) begin
            status_oe_n_o <= 1'b1;
          end
          if (slot) begin
            if (!stream_strobe_n_o) begin
              stream_strobe_n_o <= 1'b1;
            end else if (sdr_s != `SMB_SDR_STREAM) begin
              // The final word moves on the rising command edge.
              cmd_n_o <= 1'b1;
            end else begin
              stream_strobe_n_o <= 1'b0;
            end
          end
        end
        S_NEXT: begin
          if (!burst_live) begin
            master_owns_bus_n_o <= 1'b1;
            status_oe_n_o <= 1'b1;
          end
        end
        default: begin
          cnt_q <= 3'h0;
        end
      endcase
    end
  end

  // Watch for a foreign bus request while owning the bus.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_seen_q <= 1'b0;
      late_q <= 1'b0;
      pre_tick_q <= 8'h00;
      ctrl_q <= `SMB_CTRL_RST;
      count_q <= 16'h0000;
    end else begin
      if (foreign_pre) begin
        pre_seen_q <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `SMB_REG_STATUS &&
                   reg_wdata_i[`SMB_ST_PRE]) begin
        pre_seen_q <= 1'b0;
      end
      if (!foreign_pre) begin
        pre_tick_q <= 8'h00;
      end else if (tick && pre_tick_q != 8'hff) begin
        pre_tick_q <= pre_tick_q + 8'h01;
      end
      if (pre_tick_q >= `SMB_RELEASE_TICKS) begin
        late_q <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `SMB_REG_STATUS &&
                   reg_wdata_i[`SMB_ST_LATE]) begin
        late_q <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `SMB_REG_CTRL) begin
        ctrl_q <= reg_wdata_i[1:0];
      end
      if (pop) begin
        count_q <= count_q + 16'h0001;
      end else if (reg_wr_i && reg_addr_i == `SMB_REG_COUNT) begin
        count_q <= 16'h0000;
      end
    end
  end

  // Read data stand for exactly one cycle after the read strobe.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        if (reg_addr_i == `SMB_REG_CTRL) begin
          reg_rdata_o <= {30'h0, ctrl_q};
        end else if (reg_addr_i == `SMB_REG_STATUS) begin
          reg_rdata_o[`SMB_ST_STATE_LSB +: 6] <= state_q;
          reg_rdata_o[`SMB_ST_OWNER] <= ~master_owns_bus_n_o;
          reg_rdata_o[`SMB_ST_PRE] <= pre_seen_q;
          reg_rdata_o[`SMB_ST_LATE] <= late_q;
          reg_rdata_o[`SMB_ST_LVL_LSB +: FIFO_AW+1] <= fifo_level;
        end else if (reg_addr_i == `SMB_REG_COUNT) begin
          reg_rdata_o <= {16'h0000, count_q};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/smb_burst_ctrl_properties.sv
// Concurrent checks on the burst controller ports.
`timescale 1ns/100ps
`default_nettype none
module smb_burst_ctrl_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched pins
  input wire logic local_burst_req_n_i,
  input wire logic local_write_read_i,
  input wire logic local_mem_io_i,
  input wire logic master_owns_bus_n_o,
  input wire logic burst_ind_n_o,
  input wire logic bus_status0_n_o,
  input wire logic bus_status1_n_o,
  input wire logic mem_io_select_o,
  input wire logic status_oe_n_o,
  input wire logic addr_decode_latch_n_o,
  input wire logic cmd_n_o,
  input wire logic stream_strobe_n_o,
  input wire logic xfer_o,
  input wire logic [3:0] byte_en_n_o,
  input wire logic [2:0] addr_incr_o
);
  wire [2:0] code = {mem_io_select_o, bus_status1_n_o, bus_status0_n_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_status_code_legal: assert property (!status_oe_n_o |-> code inside
    {3'h1, 3'h2, 3'h5, 3'h6}) else $error("reserved status code");
  a_status_from_local: assert property ($fell(status_oe_n_o) |-> code ==
    {$past(local_mem_io_i, 3), $past(local_write_read_i, 3), !$past(local_write_read_i, 3)})
    else $error("status code does not match local inputs");
  a_len_table: assert property (xfer_o |-> {byte_en_n_o, addr_incr_o} inside
    {7'h04, 7'h71, 7'h62, 7'h43}) else $error("byte enables and step disagree");
  a_burst_drop: assert property (local_burst_req_n_i [*5] |-> burst_ind_n_o)
    else $error("burst indication kept after request withdrawn");
  a_burst_owner: assert property (master_owns_bus_n_o |=> burst_ind_n_o)
    else $error("burst indication without ownership");
  a_idle_release: assert property (master_owns_bus_n_o |-> status_oe_n_o)
    else $error("status driven without ownership");
  a_owner_cmd: assert property (!cmd_n_o |-> !master_owns_bus_n_o)
    else $error("ownership dropped during command");
  a_cmd_min: assert property ($fell(cmd_n_o) |-> !cmd_n_o [*4])
    else $error("command shorter than 100 ns");
  a_strobe_low: assert property ($fell(stream_strobe_n_o) |-> !stream_strobe_n_o [*2])
    else $error("strobe low phase too short");
  a_stream_end: assert property ($rose(cmd_n_o) |-> stream_strobe_n_o)
    else $error("command ended with strobe low");
  a_latch_then_cmd: assert property ($fell(addr_decode_latch_n_o) |->
    (!addr_decode_latch_n_o && !status_oe_n_o) [*2] ##1 (addr_decode_latch_n_o && !cmd_n_o))
    else $error("address latch strobe out of sequence");
  c_three_bytes: cover property (xfer_o && addr_incr_o == 3'h3);
  c_release: cover property ($rose(master_owns_bus_n_o));
  c_stream: cover property ($rose(stream_strobe_n_o) && !cmd_n_o);
endmodule
bind smb_burst_ctrl smb_burst_ctrl_chk u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .local_burst_req_n_i(local_burst_req_n_i), .local_write_read_i(local_write_read_i),
  .local_mem_io_i(local_mem_io_i), .master_owns_bus_n_o(master_owns_bus_n_o),
  .burst_ind_n_o(burst_ind_n_o), .bus_status0_n_o(bus_status0_n_o),
  .bus_status1_n_o(bus_status1_n_o), .mem_io_select_o(mem_io_select_o),
  .addr_decode_latch_n_o(addr_decode_latch_n_o),
  .status_oe_n_o(status_oe_n_o), .cmd_n_o(cmd_n_o), .stream_strobe_n_o(stream_strobe_n_o),
  .xfer_o(xfer_o), .byte_en_n_o(byte_en_n_o), .addr_incr_o(addr_incr_o));
`default_nettype wire

// File: tb/smb_far_model.sv
// Behavioural model of the system arbiter, release logic and addressed slave.
`timescale 1ns/100ps
`default_nettype none
module smb_far #(
  parameter int LIM = 120
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Scenario controls
  input wire logic want_i,
  input wire logic foreign_i,
  input wire logic stream_i,
  input wire logic slow_i,
  // Watched master pins
  input wire logic cmd_n_i,
  input wire logic strobe_n_i,
  input wire logic stream_en_n_i,
  // Driven pins
  output logic burst_req_n_o,
  output logic granted_n_o,
  output logic req_n_a_o,
  output logic ready_o,
  output logic [1:0] sdr_n_o
);
  logic cut_q, stop_q, strb_q, cmd_q;
  logic [2:0] wait_q;
  int tmr_q;
  assign req_n_a_o = !foreign_i;
  assign burst_req_n_o = !(want_i && !cut_q);
  assign ready_o = (wait_q == 3'h0);
  assign sdr_n_o = (stream_i && !stop_q) ? 2'h2 : 2'h3;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      granted_n_o <= 1'b1;
      {cut_q, stop_q, strb_q, cmd_q} <= 4'h3;
      wait_q <= 3'h0;
      tmr_q <= 0;
    end else begin
      granted_n_o <= burst_req_n_o;
      strb_q <= strobe_n_i;
      cmd_q <= cmd_n_i;
      // The limit stays well inside the 312-cycle release window.
      tmr_q <= (foreign_i && !burst_req_n_o) ? tmr_q + 1 : 0;
      if (tmr_q == LIM) cut_q <= 1'b1;
      else if (!foreign_i) cut_q <= 1'b0;
      if (cmd_n_i) stop_q <= 1'b0;
      else if (strb_q && !strobe_n_i && stream_en_n_i) stop_q <= 1'b1;
      if (cmd_q && !cmd_n_i) wait_q <= slow_i ? 3'h6 : 3'h0;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/smb_burst_ctrl_tb.sv
// Self-checking bench for the burst controller.
`timescale 1ns/100ps
`default_nettype none
module smb_burst_ctrl_tb;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, src_data_i = 32'h0, exp_w;
  logic src_valid_i = 1'b0, sen_n = 1'b1, wr = 1'b0, mio = 1'b0;
  logic want = 1'b0, foreign = 1'b0, strm = 1'b0, slow = 1'b0;
  logic [1:0] len = 2'h0;
  wire [1:0] sdr_n;
  wire [31:0] reg_rdata_o, xd;
  wire [3:0] ben;
  wire [2:0] inc;
  wire src_ready_o, bq_n, gnt_n, pre_n, rdy, own_n, bind_n, s0_n, s1_n, msel, oe_n;
  wire adl_n, cmd_n, stb_n, xfer;
  integer seed = 32'h4dca2d70;
  int bad_count = 0, num_checks = 0, tot = 0, i, t;
  logic [31:0] q[$];
  logic [31:0] addr_q = 32'h0, hold_q = 32'h0;
  smb_burst_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
    .src_data_i(src_data_i), .bus_granted_n_i(gnt_n), .local_burst_req_n_i(bq_n),
    .stream_enable_n_i(sen_n), .local_write_read_i(wr), .local_mem_io_i(mio),
    .xfer_len_bit0_i(len[0]), .xfer_len_bit1_i(len[1]), .bus_req_n_a_i(pre_n),
    .channel_ready_return_i(rdy), .slave_stream_req0_n_i(sdr_n[0]),
    .slave_stream_req1_n_i(sdr_n[1]), .master_owns_bus_n_o(own_n), .burst_ind_n_o(bind_n),
    .bus_status0_n_o(s0_n), .bus_status1_n_o(s1_n), .mem_io_select_o(msel),
    .status_oe_n_o(oe_n), .addr_decode_latch_n_o(adl_n), .cmd_n_o(cmd_n),
    .stream_strobe_n_o(stb_n), .xfer_o(xfer), .xfer_data_o(xd), .byte_en_n_o(ben),
    .addr_incr_o(inc));
  smb_far #(.LIM(20)) u_far (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .want_i(want),
    .foreign_i(foreign), .stream_i(strm), .slow_i(slow), .cmd_n_i(cmd_n),
    .strobe_n_i(stb_n), .stream_en_n_i(sen_n), .burst_req_n_o(bq_n),
    .granted_n_o(gnt_n), .req_n_a_o(pre_n), .ready_o(rdy), .sdr_n_o(sdr_n));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [6:0] be_of(input logic [1:0] l);
    case (l)
      2'h0: be_of = 7'h04;
      2'h1: be_of = 7'h71;
      2'h2: be_of = 7'h62;
      default: be_of = 7'h43;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(nm, e, reg_rdata_o & m);
    @(posedge sys_clk_i);
  endtask
  task automatic fill(input int n);
    logic [31:0] d;
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      src_valid_i <= 1'b1;
      src_data_i <= d;
      @(posedge sys_clk_i);
      while (src_ready_o !== 1'b1) @(posedge sys_clk_i);
      q.push_back(d);
      tot++;
    end
    src_valid_i <= 1'b0;
  endtask
  task automatic wq(input int n);
    int w;
    w = 0;
    while (q.size() > n && w < 3000) begin
      @(posedge sys_clk_i);
      w++;
    end
    chk("transfer wait", 32'h0, {31'h0, w >= 3000});
  endtask
  task automatic wown(output int w);
    w = 0;
    while (own_n !== 1'b1 && w < 3000) begin
      @(posedge sys_clk_i);
      w++;
    end
  endtask
  task automatic end_burst;
    int w;
    wq(1);
    want <= 1'b0;
    wown(w);
    wq(0);
  endtask
  // Each transfer must carry the next buffered word and the enables of the length code.
  always @(posedge sys_clk_i) begin
    if (rst_n_i && xfer === 1'b1) begin
      exp_w = (q.size() > 0) ? q.pop_front() : 32'hx;
      chk("xfer data", exp_w, xd);
      chk("byte enable", {25'h0, be_of(len)}, {25'h0, ben, inc});
      chk("drivers enabled", 32'h0, {31'h0, own_n});
    end
  end
  // Outside address counter, loaded while no burst is wanted, and the start address latch.
  always @(posedge sys_clk_i) begin
    if (want === 1'b0 && own_n === 1'b1) addr_q <= 32'h0;
    else if (xfer === 1'b1) addr_q <= addr_q + {29'h0, inc};
    if (adl_n === 1'b0) hold_q <= addr_q;
  end
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk("idle pins", 32'h7, {29'h0, own_n, bind_n, oe_n});
    rd_reg(4'h0, 32'hffffffff, 32'h0, "ctrl reset");
    rd_reg(4'h4, 32'hffff, 32'h1, "status reset");
    wr_reg(4'hc, 32'hffffffff);
    rd_reg(4'hc, 32'hffffffff, 32'h0, "unmapped");
    fill(8);
    @(negedge sys_clk_i);
    chk("buffer full", 32'h0, {31'h0, src_ready_o});
    rd_reg(4'h4, 32'hf000, 32'h8000, "fill level");
    $display("test registers and buffer done");
    wr_reg(4'h0, 32'h1);
    for (i = 0; i < 4; i++) begin
      {mio, wr} <= i[1:0];
      len <= i[1:0];
      slow <= i[0];
      repeat (8) @(posedge sys_clk_i);
      fill(i == 0 ? 0 : 2 + $unsigned($random(seed)) % 3);
      want <= 1'b1;
      end_burst;
    end
    rd_reg(4'h8, 32'hffff, tot, "word count");
    wr_reg(4'h8, 32'h0);
    rd_reg(4'h8, 32'hffff, 32'h0, "count cleared");
    $display("test normal bursts done");
    wr_reg(4'h0, 32'h3);
    len <= 2'h0;
    strm <= 1'b1;
    fill(8);
    want <= 1'b1;
    wq(7);
    chk("stream alignment", 32'h0, {30'h0, addr_q[1:0]});
    sen_n <= 1'b0;
    wq(3);
    chk("stream start held", 32'h0, {30'h0, hold_q[1:0]});
    sen_n <= 1'b1;
    end_burst;
    strm <= 1'b0;
    $display("test streaming done");
    fill(8);
    want <= 1'b1;
    wq(7);
    foreign <= 1'b1;
    wown(t);
    chk("release time", 32'h1, {31'h0, t <= 312});
    rd_reg(4'h4, 32'h600, 32'h200, "bus_req_n_a flags");
    foreign <= 1'b0;
    end_burst;
    wr_reg(4'h4, 32'h200);
    rd_reg(4'h4, 32'h600, 32'h0, "flag cleared");
    $display("test preemption done");
    finish_test;
  end
endmodule
`default_nettype wire
